// ===== rtl/l1a_regs.svh
// Register indices, field positions, reset values and timing figures
`ifndef L1A_REGS_SVH
`define L1A_REGS_SVH
`define L1A_IDX_CONF0       8'h30
`define L1A_IDX_STATUS      8'h33
`define L1A_IDX_TCMD        8'h34
`define L1A_IDX_ISTAT       8'h38
`define L1A_IDX_MASK        8'h39
`define L1A_IDX_MODE        8'h3A
`define L1A_CONF0_SWMODE    3
`define L1A_TCMD_XINF_HI    7
`define L1A_TCMD_XINF_LO    5
`define L1A_TCMD_PD         2
`define L1A_TCMD_LPA        1
`define L1A_IRQ_RIC         2
`define L1A_MODE_CFS        0
`define L1A_MASK_FIXED      8'h7B
`define L1A_MASK_RST        1'b1
`define L1A_CMD_TIM         4'h0
`define L1A_CMD_RES         4'h1
`define L1A_CMD_SSP         4'h2
`define L1A_CMD_SCP         4'h3
`define L1A_CMD_AR          4'h8
`define L1A_CMD_ARL         4'h9
`define L1A_CMD_DI          4'hF
`define L1A_IND_DR          4'h0
`define L1A_IND_RES         4'h1
`define L1A_IND_TMA         4'h2
`define L1A_IND_RSY         4'h4
`define L1A_IND_PU          4'h7
`define L1A_IND_AR          4'h8
`define L1A_IND_ARL         4'h9
`define L1A_IND_AI          4'hC
`define L1A_IND_AIL         4'hD
`define L1A_IND_DC          4'hF
`define L1A_CLK_NS          20
`define L1A_BIT_NS          2604
`define L1A_FRAME_NS        250000
`define L1A_DEACT_NS        500000
`endif

// ===== rtl/l1a_pkg.sv
// Types shared by the layer-1 activation block
package l1a_pkg;
	typedef enum logic [3:0] {
		ST_RESET, ST_DEACT, ST_PU, ST_PEND, ST_RESYNC, ST_SYNC, ST_ACT,
		ST_LP_PEND, ST_LP_SYNC, ST_LP_ACT, ST_TEST
	} l1a_state_e;
	typedef enum logic [2:0] {
		TX_I0, TX_I1W, TX_I1, TX_I3, TX_IT1, TX_IT2
	} l1a_tx_e;
	typedef enum logic [1:0] {RX_I0, RX_IX, RX_I2, RX_I4} l1a_rx_e;
	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] d;
	} l1a_chan_s;
	typedef struct packed {
		logic level;
		logic fbit;
		logic ones;
		logic sync;
	} l1a_rx_s;
	typedef struct packed {
		l1a_state_e  st;
		logic [3:0]  cmd_prev;
		logic [3:0]  cmd_cur;
		logic [2:0]  osc_sync;
		logic        oscgo;
		logic [7:0]  bit_cnt;
		logic [15:0] frm_cnt;
		logic        frm_odd;
		logic        ssp_arm;
		logic        pol;
		logic        pulse_p;
		logic        pulse_n;
		logic        burst;
		logic [15:0] timer;
		logic        clk_on;
		logic [3:0]  ind;
		l1a_tx_e     tx;
		logic        loop;
		l1a_chan_s   dn;
		l1a_chan_s   up;
		logic        sw_mode;
		logic [2:0]  xinf;
		logic        pd;
		logic        lp_a;
		logic        cfs;
		logic [7:0]  status;
		logic        irq_pend;
		logic        mask;
		logic [31:0] rdata;
	} l1a_core_s;
endpackage

// ===== rtl/l1a_fsm.sv
// Layer-1 activation state machine with command filter, test pulses and APB
`timescale 1ns/1ps
`default_nettype none
`include "l1a_regs.svh"
// Notes on behaviour
// RQ1: Layer-2 side drives 4-bit commands on the C/I channel to steer layer 1.
// RQ2: Device reports its state with 4-bit indications on the same channel.
// RQ3: Timing command 0000 requests running clocks for the layer-2 device.
// RQ4: Single-pulse test sends one bit-wide pulse per frame, alternating.
// RQ5: Continuous-pulse test sends unbroken bit-wide alternating pulses.
// RQ6: Both test modes indicate test-mode acknowledge 0010.
// RQ7: Software mode stops the state machine; transmit comes from register.
// RQ8: Software mode updates status continuously, flags change unless masked; the code sets the flag even when masked and masks only the irq output.
// RQ9: Reading the receive status register clears the pending change flag.
// RQ10: Chip reset puts the machine in reset state, same as reset command.
// RQ11: Reset state indicates 0001, sends info 0, keeps clocks running.
// RQ12: Reset state ignores activation; only command 1111 leads to deactivated.
// RQ13: Deactivated stops clocks 500 us after entry on info 0, oscgo low; the code also requires cfs set.
// RQ14: Power-up sends info 0 with clocks running and indicates 0111.
// RQ15: Activation request 1000 sends info 1w at 2 kHz awaiting info 2.
// RQ16: Signal seen but unsynchronized indicates resynchronization 0100.
// RQ17: Synchronized on info 2 sends info 1 and indicates 1000.
// RQ18: Synchronized on info 4 sends info 3, passes channels, indicates 1100.
// RQ19: Loop command 1001 loops transmitter, sends info 1, indicates 1001 synced.
// RQ20: Loop synchronized sends info 3; looped info 3 gives transparency, 1101.
// RQ21: Deactivation indicates 1111; clocks stop too when shutdown select set.
// RQ22: Receiver classifies line as info 0, info 2, info 4 or info X.
// RQ23: Channels pass only when activated, loop included; otherwise all ones.
// RQ24: Unassigned command codes are ignored and leave the state unchanged.
// RQ25: A new command acts only after equal codes in two consecutive frames.
module l1a_fsm
	import l1a_pkg::*;
#(
	parameter int FRAME_CYC = `L1A_FRAME_NS / `L1A_CLK_NS,
	parameter int DEACT_CYC = `L1A_DEACT_NS / `L1A_CLK_NS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  ci_cmd,
	input  wire logic        ci_frame,
	output logic      [3:0]  ci_ind,
	input  wire l1a_rx_s     rx_line,
	input  wire logic        oscgo_pin,
	output l1a_tx_e          tx_info,
	output logic             tx_burst,
	output logic             tx_pulse_pos,
	output logic             tx_pulse_neg,
	output logic             loop_enable,
	output logic             clocks_on,
	input  wire l1a_chan_s   dn_in,
	input  wire l1a_chan_s   up_in,
	output l1a_chan_s        dn_out,
	output l1a_chan_s        up_out,
	output logic             receive_change_irq
);
	localparam int BIT_CYC = `L1A_BIT_NS / `L1A_CLK_NS;
	localparam logic [7:0]  BIT_LAST = 8'(BIT_CYC - 1);
	localparam logic [15:0] FRM_LAST = 16'(FRAME_CYC - 1);
	localparam logic [15:0] DEACT_N = 16'(DEACT_CYC);
	localparam l1a_chan_s   ALL_ONES = '1;

	function automatic logic cmd_known(input logic [3:0] c);
		cmd_known = (c == `L1A_CMD_TIM) || (c == `L1A_CMD_RES) ||
			(c == `L1A_CMD_SSP) || (c == `L1A_CMD_SCP) ||
			(c == `L1A_CMD_AR) || (c == `L1A_CMD_ARL) ||
			(c == `L1A_CMD_DI);
	endfunction

	function automatic l1a_rx_e classify(input l1a_rx_s r);
		if (!r.level)
			classify = RX_I0;
		else if (r.sync && r.fbit)
			classify = r.ones ? RX_I2 : RX_I4;
		else
			classify = RX_IX;
	endfunction

	function automatic logic idx_hit(input logic [11:0] a,
		input logic [7:0] idx);
		idx_hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(a[9:2] == idx);
	endfunction

	l1a_core_s r;
	l1a_core_s n;
	logic      bit_tick;
	logic      frame_tick;
	logic      cmd_new;
	logic      acc;
	logic      mapped;
	logic      rd_status;
	l1a_rx_e   info;
	logic      transparent;
	logic      stop_clk;
	logic [7:0] next_status;
	logic [7:0] paddr_idx;

	assign pready = 1'b1;
	assign acc = psel && penable;
	assign paddr_idx = paddr[9:2];
	assign mapped = idx_hit(paddr, `L1A_IDX_CONF0) ||
		idx_hit(paddr, `L1A_IDX_STATUS) || idx_hit(paddr, `L1A_IDX_TCMD) ||
		idx_hit(paddr, `L1A_IDX_ISTAT) || idx_hit(paddr, `L1A_IDX_MASK) ||
		idx_hit(paddr, `L1A_IDX_MODE);
	assign pslverr = acc && !mapped;
	assign prdata = r.rdata;
	assign ci_ind = r.ind; // see RQ2
	assign tx_info = r.tx;
	assign tx_burst = r.burst;
	assign tx_pulse_pos = r.pulse_p;
	assign tx_pulse_neg = r.pulse_n;
	assign loop_enable = r.loop;
	assign clocks_on = r.clk_on;
	assign dn_out = r.dn;
	assign up_out = r.up;
	assign receive_change_irq = r.irq_pend && !r.mask;

	always_comb begin
		n = r;
		cmd_new = 1'b0;
		transparent = 1'b0;
		stop_clk = 1'b0;
		info = classify(rx_line); // see RQ22
		// Only the last two stages are compared; oscgo takes the last stage only when those two agree
		n.osc_sync = {r.osc_sync[1:0], oscgo_pin};
		if (r.osc_sync[1] == r.osc_sync[2])
			n.oscgo = r.osc_sync[2];
		bit_tick = (r.bit_cnt == BIT_LAST);
		n.bit_cnt = bit_tick ? 8'h00 : r.bit_cnt + 8'h01;
		frame_tick = (r.frm_cnt == FRM_LAST);
		n.frm_cnt = frame_tick ? 16'h0000 : r.frm_cnt + 16'h0001;
		if (frame_tick)
			n.frm_odd = !r.frm_odd;
		// Two equal frames are needed; a corrupted one never changes state
		if (ci_frame) begin
			n.cmd_prev = ci_cmd;
			if (ci_cmd == r.cmd_prev && ci_cmd != r.cmd_cur &&
				cmd_known(ci_cmd)) begin // see RQ24
				n.cmd_cur = ci_cmd; // see RQ25
				cmd_new = 1'b1; // see RQ1
			end
		end
		if (!r.sw_mode && cmd_new) begin
			unique case (n.cmd_cur)
				`L1A_CMD_RES: n.st = ST_RESET; // see RQ10
				`L1A_CMD_SSP, `L1A_CMD_SCP: n.st = ST_TEST;
				`L1A_CMD_DI: n.st = ST_DEACT; // see RQ12
				`L1A_CMD_TIM: begin
					if (r.st == ST_DEACT || r.st == ST_TEST)
						n.st = ST_PU; // see RQ3
				end
				`L1A_CMD_AR: begin
					if (r.st == ST_DEACT || r.st == ST_PU || r.st == ST_TEST)
						n.st = ST_PEND; // see RQ15
				end
				`L1A_CMD_ARL: begin
					if (r.st == ST_DEACT || r.st == ST_PU || r.st == ST_TEST)
						n.st = ST_LP_PEND; // see RQ19
				end
				default: n.st = r.st;
			endcase
		end else if (!r.sw_mode) begin
			unique case (r.st)
				ST_DEACT, ST_PU, ST_PEND: begin
					if (info != RX_I0)
						n.st = ST_RESYNC;
				end
				ST_RESYNC: begin
					if (info == RX_I2)
						n.st = ST_SYNC;
					else if (info == RX_I4)
						n.st = ST_ACT;
					else if (info == RX_I0)
						n.st = ST_RESET;
				end
				ST_SYNC: begin
					if (info == RX_I4)
						n.st = ST_ACT;
					else if (info == RX_I0)
						n.st = ST_RESET;
					else if (info == RX_IX)
						n.st = ST_RESYNC;
				end
				ST_ACT: begin
					if (info == RX_I0)
						n.st = ST_RESET;
					else if (info == RX_IX)
						n.st = ST_RESYNC;
				end
				ST_LP_PEND: begin
					if (rx_line.sync)
						n.st = ST_LP_SYNC;
				end
				ST_LP_SYNC: begin
					if (info == RX_I4)
						n.st = ST_LP_ACT;
				end
				ST_RESET, ST_LP_ACT, ST_TEST: n.st = r.st;
			endcase
		end
		// Deactivation timer restarts whenever its conditions lapse
		if (r.st == ST_DEACT && info == RX_I0 && !r.oscgo) begin
			if (r.timer != DEACT_N)
				n.timer = r.timer + 16'h0001;
		end else begin
			n.timer = 16'h0000;
		end
		n.loop = 1'b0;
		unique case (r.st)
			ST_RESET: begin
				n.ind = `L1A_IND_RES; // see RQ11
				n.tx = TX_I0;
			end
			ST_DEACT: begin
				n.ind = `L1A_IND_DC; // see RQ21
				n.tx = TX_I0;
				stop_clk = (r.timer == DEACT_N) && r.cfs; // see RQ13
			end
			ST_PU: begin
				n.ind = `L1A_IND_PU; // see RQ14
				n.tx = TX_I0;
			end
			ST_PEND: begin
				n.ind = `L1A_IND_PU;
				n.tx = TX_I1W; // see RQ15
			end
			ST_RESYNC: begin
				n.ind = `L1A_IND_RSY; // see RQ16
				n.tx = TX_I0;
			end
			ST_SYNC: begin
				n.ind = `L1A_IND_AR; // see RQ17
				n.tx = TX_I1;
			end
			ST_ACT: begin
				n.ind = `L1A_IND_AI; // see RQ18
				n.tx = TX_I3;
				transparent = 1'b1;
			end
			ST_LP_PEND: begin
				n.ind = `L1A_IND_RSY;
				n.tx = TX_I1;
				n.loop = 1'b1;
			end
			ST_LP_SYNC: begin
				n.ind = `L1A_IND_ARL; // see RQ19
				n.tx = TX_I3; // see RQ20
				n.loop = 1'b1;
			end
			ST_LP_ACT: begin
				n.ind = `L1A_IND_AIL; // see RQ20
				n.tx = TX_I3;
				n.loop = 1'b1;
				transparent = 1'b1;
			end
			ST_TEST: begin
				n.ind = `L1A_IND_TMA; // see RQ6
				n.tx = (r.cmd_cur == `L1A_CMD_SSP) ? TX_IT2 : TX_IT1;
			end
		endcase
		// Software mode owns the transmitter and loop outright
		if (r.sw_mode) begin
			n.tx = l1a_tx_e'(r.xinf); // see RQ7
			n.loop = r.lp_a;
			stop_clk = r.pd;
			transparent = 1'b0;
		end
		n.clk_on = !stop_clk;
		n.dn = transparent ? dn_in : ALL_ONES; // see RQ23
		n.up = transparent ? up_in : ALL_ONES;
		n.burst = frame_tick && (r.tx == TX_I1 || r.tx == TX_I3 ||
			(r.tx == TX_I1W && r.frm_odd));
		if (frame_tick)
			n.ssp_arm = 1'b1;
		if (bit_tick) begin
			n.pulse_p = 1'b0;
			n.pulse_n = 1'b0;
			if (r.tx == TX_IT1 || (r.tx == TX_IT2 && r.ssp_arm)) begin
				n.pulse_p = r.pol; // see RQ5
				n.pulse_n = !r.pol;
				n.pol = !r.pol; // see RQ4
				n.ssp_arm = frame_tick;
			end
		end
		next_status = {info, 3'b000, rx_line.sync, 2'b00};
		n.status = next_status; // see RQ8
		rd_status = acc && !pwrite && idx_hit(paddr, `L1A_IDX_STATUS);
		if (rd_status)
			n.irq_pend = 1'b0; // see RQ9
		// A change in the clearing cycle still raises the flag
		if (r.sw_mode && next_status != r.status)
			n.irq_pend = 1'b1;
		if (acc && pwrite) begin
			unique case (paddr_idx)
				`L1A_IDX_CONF0: n.sw_mode = pwdata[`L1A_CONF0_SWMODE];
				`L1A_IDX_TCMD: begin
					n.xinf = pwdata[`L1A_TCMD_XINF_HI:`L1A_TCMD_XINF_LO];
					n.pd = pwdata[`L1A_TCMD_PD];
					n.lp_a = pwdata[`L1A_TCMD_LPA];
				end
				`L1A_IDX_MASK: n.mask = pwdata[`L1A_IRQ_RIC];
				`L1A_IDX_MODE: n.cfs = pwdata[`L1A_MODE_CFS];
				default: n.mask = r.mask;
			endcase
		end
		if (psel && !penable && !pwrite) begin
			n.rdata = 32'h0000_0000;
			unique case (paddr_idx)
				`L1A_IDX_CONF0: n.rdata[`L1A_CONF0_SWMODE] = r.sw_mode;
				`L1A_IDX_STATUS: n.rdata[7:0] = r.status;
				`L1A_IDX_TCMD: begin
					n.rdata[`L1A_TCMD_XINF_HI:`L1A_TCMD_XINF_LO] = r.xinf;
					n.rdata[`L1A_TCMD_PD] = r.pd;
					n.rdata[`L1A_TCMD_LPA] = r.lp_a;
				end
				`L1A_IDX_ISTAT: n.rdata[`L1A_IRQ_RIC] = r.irq_pend;
				`L1A_IDX_MASK: begin
					n.rdata[7:0] = `L1A_MASK_FIXED;
					n.rdata[`L1A_IRQ_RIC] = r.mask;
				end
				`L1A_IDX_MODE: n.rdata[`L1A_MODE_CFS] = r.cfs;
				default: n.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= ST_RESET; // see RQ10
			r.ind <= `L1A_IND_RES;
			r.tx <= TX_I0;
			r.clk_on <= 1'b1;
			r.cmd_prev <= `L1A_CMD_RES;
			r.cmd_cur <= `L1A_CMD_RES;
			r.dn <= ALL_ONES;
			r.up <= ALL_ONES;
			r.mask <= `L1A_MASK_RST;
		end else begin
			r <= n;
		end
	end
endmodule
`default_nettype wire

// ===== tb/l1a_fsm_assertions.sv
// Port-level assertions for the layer-1 activation block
`timescale 1ns/1ps
`default_nettype none
module l1a_fsm_checker
	import l1a_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  ci_ind,
	input wire l1a_tx_e     tx_info,
	input wire logic        tx_pulse_pos,
	input wire logic        clocks_on,
	input wire l1a_chan_s   dn_out,
	input wire l1a_chan_s   up_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] hi_cnt;
	logic       acc;
	logic       act;
	assign acc = psel && penable;
	assign act = ci_ind == 4'hC || ci_ind == 4'hD;
	// Length of the current positive pulse, cleared while low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= tx_pulse_pos ? hi_cnt + 8'h01 : 8'h00;
	end
	// Three idle cycles absorb the one-edge lag between state and indication
	sequence s_idle3;
		!act [*3];
	endsequence
	sequence s_pos_end;
		$fell(tx_pulse_pos) ##1 tx_info inside {TX_IT1, TX_IT2};
	endsequence
	a_reset_values: assert property (disable iff (1'b0) !presetn |->
		ci_ind == 4'h1 && tx_info == TX_I0 && clocks_on)
		else $error("reset outputs wrong");
	a_ready_high: assert property (acc |-> pready)
		else $error("pready low in access");
	a_unmapped_err: assert property (acc |->
		pslverr == !(paddr inside {12'h0C0, 12'h0CC, 12'h0D0, 12'h0E0,
		12'h0E4, 12'h0E8})) else $error("pslverr wrong");
	a_err_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_chan_forced: assert property (s_idle3 |->
		$past(dn_out) == 18'h3FFFF && $past(up_out) == 18'h3FFFF)
		else $error("channels not all ones");
	a_test_ack: assert property (
		tx_info inside {TX_IT1, TX_IT2} |-> ci_ind == 4'h2)
		else $error("test mode without ack");
	a_sync_tx: assert property (ci_ind == 4'h8 |-> tx_info == TX_I1)
		else $error("sync without info 1");
	a_act_tx: assert property (ci_ind == 4'hC |-> tx_info == TX_I3)
		else $error("active without info 3");
	a_deact_line: assert property (ci_ind == 4'hF |-> tx_info == TX_I0)
		else $error("line up while deactivated");
	a_pulse_width: assert property (s_pos_end |-> $past(hi_cnt) == 8'h82)
		else $error("pulse width wrong");
endmodule
bind l1a_fsm l1a_fsm_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .ci_ind, .tx_info, .tx_pulse_pos,
	.clocks_on, .dn_out, .up_out);
`default_nettype wire

// ===== tb/l1a_line_card.sv
// Exchange line card model seen through the receiver flags
`timescale 1ns/1ps
`default_nettype none
module l1a_line_card
	import l1a_pkg::*;
(
	input  wire l1a_rx_e mode,
	input  wire logic    loop,
	input  wire l1a_tx_e tx,
	output l1a_rx_s      rx
);
	l1a_rx_e cls;
	// In the loop the receiver hears info 1 as info 2 and info 3 as info 4
	assign cls = !loop ? mode : tx == TX_I3 ? RX_I4 :
		tx == TX_I1 ? RX_I2 : RX_I0;
	always_comb begin
		case (cls)
		RX_I0: rx = 4'b0101;
		RX_IX: rx = 4'b1010;
		RX_I2: rx = 4'b1111;
		default: rx = 4'b1101;
		endcase
	end
endmodule
`default_nettype wire

// ===== tb/l1a_fsm_test.sv
// Self-checking bench for the layer-1 activation block
`timescale 1ns/1ps
`default_nettype none
module l1a_fsm_test
	import l1a_pkg::*;
;
	localparam int FC = 400;
	localparam int DC = 40;
	logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
	logic        ci_frame = 0, oscgo_pin = 0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, r;
	logic [3:0]  ci_cmd = 4'h1, ci_ind;
	l1a_chan_s   dn_in = 18'h2A5C3, up_in = 18'h15A3C, dn_out, up_out;
	l1a_rx_e     mode = RX_I0;
	l1a_rx_s     rx_line;
	l1a_tx_e     tx_info;
	logic [31:0] prdata;
	logic        pready, pslverr, tx_burst, tx_pulse_pos, tx_pulse_neg;
	logic        loop_enable, clocks_on, irq;
	int          n_mismatch = 0, checked = 0, rp, rn, nb, idle;
	always #10 pclk = ~pclk;
	l1a_fsm #(.FRAME_CYC(FC), .DEACT_CYC(DC)) dut (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ci_cmd,
		.ci_frame, .ci_ind, .rx_line, .oscgo_pin, .tx_info, .tx_burst,
		.tx_pulse_pos, .tx_pulse_neg, .loop_enable, .clocks_on, .dn_in, .up_in,
		.dn_out, .up_out, .receive_change_irq(irq));
	l1a_line_card card (.mode, .loop(loop_enable), .tx(tx_info), .rx(rx_line));
	task conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task see(input logic [3:0] ind, input l1a_tx_e tx);
		chk("ci_ind", ind, ci_ind);
		chk("tx_info", tx, tx_info);
	endtask
	// Request held until pready is seen high with psel and penable
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task cmd(input logic [3:0] c, input int n);
		repeat (n) begin
			@(posedge pclk);
			ci_cmd <= c;
			ci_frame <= 1;
			@(posedge pclk);
			ci_frame <= 0;
			wt(4);
		end
	endtask
	task count(input int cyc);
		logic lp, ln;
		lp = tx_pulse_pos;
		ln = tx_pulse_neg;
		{rp, rn, nb, idle} = 0;
		// Falling edge: registered outputs have settled by then
		repeat (cyc) begin
			@(negedge pclk);
			rp += tx_pulse_pos & !lp;
			rn += tx_pulse_neg & !ln;
			nb += tx_burst;
			idle += !(tx_pulse_pos | tx_pulse_neg);
			lp = tx_pulse_pos;
			ln = tx_pulse_neg;
		end
	endtask
	task t_reset;
		see(4'h1, TX_I0);
		chk("clocks_on", 1, clocks_on);
		chk("dn_out", 32'h3FFFF, dn_out);
		apb(0, 12'h0E4, 0);
		chk("mask", 32'h7F, r);
		apb(0, 12'h0C0, 0);
		chk("conf0", 32'h0, r);
		apb(0, 12'h0C4, 0);
		chk("unmapped err", 1, e);
		$display("t_reset done");
	endtask
	task t_guard;
		cmd(4'h8, 2);
		see(4'h1, TX_I0);
		cmd(4'h5, 2);
		see(4'h1, TX_I0);
		cmd(4'hF, 1);
		see(4'h1, TX_I0);
		cmd(4'hF, 1);
		see(4'hF, TX_I0);
		$display("t_guard done");
	endtask
	task t_line;
		apb(1, 12'h0E8, 32'h1);
		wt(DC + 20);
		chk("clocks_on", 0, clocks_on);
		cmd(4'h0, 2);
		chk("clocks_on", 1, clocks_on);
		see(4'h7, TX_I0);
		mode <= RX_IX;
		wt(5);
		see(4'h4, TX_I0);
		mode <= RX_I2;
		wt(5);
		see(4'h8, TX_I1);
		mode <= RX_I4;
		wt(5);
		see(4'hC, TX_I3);
		chk("dn_out", dn_in, dn_out);
		chk("up_out", up_in, up_out);
		$display("t_line done");
	endtask
	task t_wake;
		mode <= RX_I0;
		wt(5);
		see(4'h1, TX_I0);
		cmd(4'hF, 2);
		see(4'hF, TX_I0);
		cmd(4'h8, 2);
		see(4'h7, TX_I1W);
		count(4 * FC);
		chk("wake bursts", 2, nb);
		cmd(4'hF, 2);
		cmd(4'h9, 2);
		wt(10);
		chk("loop_enable", 1, loop_enable);
		see(4'hD, TX_I3);
		$display("t_wake done");
	endtask
	task t_pulse;
		cmd(4'h2, 2);
		wt(200);
		see(4'h2, TX_IT2);
		// Start at a pulse so the window holds exactly four of them
		@(posedge tx_pulse_pos or posedge tx_pulse_neg);
		e = tx_pulse_pos;
		count(3 * FC + 200);
		chk("pos pulses", 2, rp + e);
		chk("neg pulses", 2, rn + !e);
		cmd(4'h1, 2);
		see(4'h1, TX_I0);
		cmd(4'h3, 2);
		wt(300);
		see(4'h2, TX_IT1);
		count(1040);
		chk("pulses", 8, rp + rn);
		chk("gaps", 0, idle);
		cmd(4'h1, 2);
		$display("t_pulse done");
	endtask
	task t_soft;
		apb(1, 12'h0C0, 32'h8);
		apb(1, 12'h0D0, 32'h60);
		wt(3);
		chk("sw tx", TX_I3, tx_info);
		apb(1, 12'h0E4, 32'h7B);
		apb(0, 12'h0CC, 0);
		mode <= RX_I2;
		wt(5);
		chk("irq", 1, irq);
		apb(0, 12'h0CC, 0);
		chk("status", 32'h80, r & 32'hC0);
		wt(2);
		chk("irq", 0, irq);
		presetn <= 0;
		wt(2);
		see(4'h1, TX_I0);
		presetn <= 1;
		$display("t_soft done");
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		conclude;
	end
	initial begin
		presetn <= 0;
		wt(4);
		presetn <= 1;
		t_reset;
		t_guard;
		t_line;
		t_wake;
		t_pulse;
		t_soft;
		conclude;
	end
endmodule
`default_nettype wire
